// [design/port_mux_defines.svh]
`ifndef PORT_MUX_DEFINES_SVH
`define PORT_MUX_DEFINES_SVH

// Register byte offsets
`define OFS_MCU_CONTROL   8'h00
`define OFS_PA_DATA       8'h04
`define OFS_PA_DIR        8'h08
`define OFS_PA_PINS       8'h0C
`define OFS_PB_DATA       8'h10
`define OFS_PB_DIR        8'h14
`define OFS_PB_PINS       8'h18
`define OFS_PB_PCMASK     8'h1C
`define OFS_PB_FUNC       8'h20

// Control register fields
`define BIT_SCAN_PORT_DISABLE     7
`define BIT_GLOBAL_PULLUP_DISABLE 4
`define BIT_VECTOR_TABLE_SELECT   1
`define BIT_VECTOR_CHANGE_ENABLE  0
`define MCU_CONTROL_WR_MASK       8'h93
`define MCU_CONTROL_RESET         8'h00

// Port B function register fields
`define BIT_PC_GROUP_ENABLE       0
`define BIT_PB7_TIMER1_SELECT     1
`define PB_FUNC_WR_MASK           8'h03

// Reset value shared by the port registers
`define PORT_REG_RESET            8'h00

`endif

// [design/port_mux_pkg.sv]
package port_mux_pkg;

  // Resolved controls of one pad
  typedef struct packed {
    logic oe;
    logic out;
    logic pu;
    logic ie;
  } pin_ctl_type;

  // Answers on the register bus
  typedef enum logic [1:0] {
    RESP_OKAY   = 2'b00,
    RESP_SLVERR = 2'b10
  } axi_resp_type;

endpackage

// [design/port_alternate_function_mux.sv]
`timescale 1ns/1ps
`include "port_mux_defines.svh"

module port_alternate_function_mux
  import port_mux_pkg::*;
#(
  parameter int PIN_COUNT = 8
)
(
  // Clock and reset
  input  wire logic                  clk_sys_i,
  input  wire logic                  arst_n_i,
  // AXI4-Lite slave
  input  wire logic [7:0]            s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output port_mux_pkg::axi_resp_type s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [7:0]            s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output port_mux_pkg::axi_resp_type s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // Control register levels
  output logic                       scan_port_disable_o,
  output logic                       vector_table_select_o,
  output logic                       vector_change_enable_o,
  // Sleep state from power control
  input  wire logic                  sleep_i,
  // External memory interface
  input  wire logic                  ext_mem_enable_i,
  input  wire logic                  mem_wr_strobe_i,
  input  wire logic                  address_phase_active_i,
  input  wire logic [PIN_COUNT-1:0]  mem_addr_lo_i,
  input  wire logic [PIN_COUNT-1:0]  mem_wdata_i,
  output logic [PIN_COUNT-1:0]       mem_rdata_o,
  // Timer compare outputs
  input  wire logic                  timer0_compare_out_a_i,
  input  wire logic                  timer0_compare_en_a_i,
  input  wire logic                  timer1_compare_out_a_i,
  input  wire logic                  timer1_compare_en_a_i,
  input  wire logic                  timer1_compare_out_b_i,
  input  wire logic                  timer1_compare_en_b_i,
  input  wire logic                  timer1_compare_out_c_i,
  input  wire logic                  timer1_compare_en_c_i,
  input  wire logic                  timer2_compare_out_a_i,
  input  wire logic                  timer2_compare_en_a_i,
  // SPI, serial programming and pin change
  input  wire logic                  spi_enable_i,
  input  wire logic                  spi_master_i,
  input  wire logic                  spi_slave_out_i,
  input  wire logic                  spi_master_out_i,
  input  wire logic                  spi_sck_out_i,
  input  wire logic                  prog_mode_i,
  input  wire logic                  prog_serial_data_out_i,
  output logic                       spi_master_in_o,
  output logic                       spi_slave_in_o,
  output logic                       spi_sck_in_o,
  output logic                       spi_ss_in_o,
  output logic                       prog_serial_data_in_o,
  output logic [PIN_COUNT-1:0]       pin_change_src_o,
  // Port A pads
  input  wire logic [PIN_COUNT-1:0]  pa_pad_i,
  output logic [PIN_COUNT-1:0]       pa_pad_o,
  output logic [PIN_COUNT-1:0]       pa_pad_oe_o,
  output logic [PIN_COUNT-1:0]       pa_pullup_o,
  // Port B pads
  input  wire logic [PIN_COUNT-1:0]  pb_pad_i,
  output logic [PIN_COUNT-1:0]       pb_pad_o,
  output logic [PIN_COUNT-1:0]       pb_pad_oe_o,
  output logic [PIN_COUNT-1:0]       pb_pullup_o
);
  import port_mux_pkg::*;

  // Generic pad resolution shared by every pin of both ports
  function automatic pin_ctl_type resolve_pin(
    input logic dir_bit, input logic port_bit, input logic global_pullup_disable,
    input logic pullup_override_en, input logic pullup_override_val, input logic direction_override_en, input logic direction_override_val,
    input logic value_override_en, input logic value_override_val, input logic input_enable_override_en, input logic input_enable_override_val,
    input logic sleep);
    pin_ctl_type c;
    c.oe  = direction_override_en ? direction_override_val : dir_bit;
    c.out = (value_override_en && c.oe) ? value_override_val : port_bit;
    c.pu  = pullup_override_en ? pullup_override_val : (!dir_bit && port_bit && !global_pullup_disable);
    c.ie  = input_enable_override_en ? input_enable_override_val : !sleep;
    return c;
  endfunction

  logic [7:0]           mcu_control_r;
  logic [PIN_COUNT-1:0] pa_data_r;
  logic [PIN_COUNT-1:0] pa_dir_r;
  logic [PIN_COUNT-1:0] pb_data_r;
  logic [PIN_COUNT-1:0] pb_dir_r;
  logic [PIN_COUNT-1:0] pb_pcmask_r;
  logic [7:0]           pb_func_r;
  logic [PIN_COUNT-1:0] pa_meta_r;
  logic [PIN_COUNT-1:0] pa_sync_r;
  logic [PIN_COUNT-1:0] pb_meta_r;
  logic [PIN_COUNT-1:0] pb_sync_r;
  logic                 global_pullup_disable;

  assign global_pullup_disable = mcu_control_r[`BIT_GLOBAL_PULLUP_DISABLE];

  // ---------------- Register bus ----------------
  logic       aw_held_r;
  logic       w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic       wr_go;
  logic       wr_hit;

  // Address and data are taken independently, in either order
  assign s_axi_awready_o = !aw_held_r && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_r && !s_axi_bvalid_o;
  assign wr_go           = aw_held_r && w_held_r && !s_axi_bvalid_o;
  assign wr_hit          = wr_go && w_strb_r[0];

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0000_0000;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid_i && s_axi_awready_o)
      begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr_i;
      end
      else if (wr_go)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid_i && s_axi_wready_o)
      begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata_i;
        w_strb_r <= s_axi_wstrb_i;
      end
      else if (wr_go)
        w_held_r <= 1'b0;
    end
  end

  // True when an offset names a register
  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `OFS_MCU_CONTROL, `OFS_PA_DATA, `OFS_PA_DIR, `OFS_PA_PINS,
      `OFS_PB_DATA, `OFS_PB_DIR, `OFS_PB_PINS, `OFS_PB_PCMASK,
      `OFS_PB_FUNC: addr_mapped = 1'b1;
      default:      addr_mapped = 1'b0;
    endcase
  endfunction

  // Write response, one cycle after both halves are held
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= addr_mapped(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready_i)
      s_axi_bvalid_o <= 1'b0;
  end

  // Writable registers; only byte lane 0 carries data
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mcu_control_r <= `MCU_CONTROL_RESET;
      pa_data_r     <= `PORT_REG_RESET;
      pa_dir_r      <= `PORT_REG_RESET;
      pb_data_r     <= `PORT_REG_RESET;
      pb_dir_r      <= `PORT_REG_RESET;
      pb_pcmask_r   <= `PORT_REG_RESET;
      pb_func_r     <= `PORT_REG_RESET;
    end
    else if (wr_hit)
    begin
      case (aw_addr_r)
        `OFS_MCU_CONTROL: mcu_control_r <= w_data_r[7:0] & `MCU_CONTROL_WR_MASK;
        `OFS_PA_DATA:     pa_data_r     <= w_data_r[PIN_COUNT-1:0];
        `OFS_PA_DIR:      pa_dir_r      <= w_data_r[PIN_COUNT-1:0];
        `OFS_PB_DATA:     pb_data_r     <= w_data_r[PIN_COUNT-1:0];
        `OFS_PB_DIR:      pb_dir_r      <= w_data_r[PIN_COUNT-1:0];
        `OFS_PB_PCMASK:   pb_pcmask_r   <= w_data_r[PIN_COUNT-1:0];
        `OFS_PB_FUNC:     pb_func_r     <= w_data_r[7:0] & `PB_FUNC_WR_MASK;
        default:          pb_func_r     <= pb_func_r;
      endcase
    end
  end

  // Read channel: one answer at a time, data registered
  assign s_axi_arready_o = !s_axi_rvalid_o;

  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h0000_0000;
      s_axi_rresp_o  <= RESP_OKAY;
    end
    else if (s_axi_arvalid_i && s_axi_arready_o)
    begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= addr_mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr_i)
        `OFS_MCU_CONTROL: s_axi_rdata_o <= {24'h00_0000, mcu_control_r};
        `OFS_PA_DATA:     s_axi_rdata_o <= {24'h00_0000, pa_data_r};
        `OFS_PA_DIR:      s_axi_rdata_o <= {24'h00_0000, pa_dir_r};
        `OFS_PA_PINS:     s_axi_rdata_o <= {24'h00_0000, pa_sync_r};
        `OFS_PB_DATA:     s_axi_rdata_o <= {24'h00_0000, pb_data_r};
        `OFS_PB_DIR:      s_axi_rdata_o <= {24'h00_0000, pb_dir_r};
        `OFS_PB_PINS:     s_axi_rdata_o <= {24'h00_0000, pb_sync_r};
        `OFS_PB_PCMASK:   s_axi_rdata_o <= {24'h00_0000, pb_pcmask_r};
        `OFS_PB_FUNC:     s_axi_rdata_o <= {24'h00_0000, pb_func_r};
        default:          s_axi_rdata_o <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rready_i)
      s_axi_rvalid_o <= 1'b0;
  end

  assign scan_port_disable_o    = mcu_control_r[`BIT_SCAN_PORT_DISABLE];
  assign vector_table_select_o  = mcu_control_r[`BIT_VECTOR_TABLE_SELECT];
  assign vector_change_enable_o = mcu_control_r[`BIT_VECTOR_CHANGE_ENABLE];

  // ---------------- Pad input synchronisers ----------------
  // Pads are asynchronous; nothing reads the first stage but the second
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pa_meta_r <= `PORT_REG_RESET;
      pa_sync_r <= `PORT_REG_RESET;
      pb_meta_r <= `PORT_REG_RESET;
      pb_sync_r <= `PORT_REG_RESET;
    end
    else
    begin
      pa_meta_r <= pa_pad_i;
      pa_sync_r <= pa_meta_r;
      pb_meta_r <= pb_pad_i;
      pb_sync_r <= pb_meta_r;
    end
  end

  // ---------------- Override sources ----------------
  logic                 addr_or_wr;
  logic                 spi_mst;
  logic                 spi_slv;
  logic                 pc_group;
  logic [PIN_COUNT-1:0] pa_value_override_val;
  logic [PIN_COUNT-1:0] pb_pullup_override_en;
  logic [PIN_COUNT-1:0] pb_pullup_override_val;
  logic [PIN_COUNT-1:0] pb_direction_override_en;
  logic [PIN_COUNT-1:0] pb_direction_override_val;
  logic [PIN_COUNT-1:0] pb_value_override_en;
  logic [PIN_COUNT-1:0] pb_value_override_val;
  logic [PIN_COUNT-1:0] pb_input_enable_override_en;

  // Address-active comes straight from the controller's phase level
  assign addr_or_wr = mem_wr_strobe_i || address_phase_active_i;
  assign spi_mst    = spi_enable_i && spi_master_i;
  assign spi_slv    = spi_enable_i && !spi_master_i;
  assign pc_group   = pb_func_r[`BIT_PC_GROUP_ENABLE];

  // Port A value: address in the address phase, write data under the strobe
  assign pa_value_override_val = ({PIN_COUNT{address_phase_active_i}} & mem_addr_lo_i) |
                   ({PIN_COUNT{mem_wr_strobe_i}} & mem_wdata_i);

  // Port B overrides per pin
  always_comb
  begin
    pb_pullup_override_en  = '0;
    pb_pullup_override_val  = '0;
    pb_direction_override_en  = '0;
    pb_direction_override_val  = '0;
    pb_value_override_en  = '0;
    pb_value_override_val  = '0;
    pb_input_enable_override_en = pb_pcmask_r & {PIN_COUNT{pc_group}};
    // Bit 7: one of two timer outputs, chosen in the function register
    if (pb_func_r[`BIT_PB7_TIMER1_SELECT])
    begin
      pb_value_override_en[7] = timer1_compare_en_c_i;
      pb_value_override_val[7] = timer1_compare_out_c_i;
    end
    else
    begin
      pb_value_override_en[7] = timer0_compare_en_a_i;
      pb_value_override_val[7] = timer0_compare_out_a_i;
    end
    pb_value_override_en[6] = timer1_compare_en_b_i;
    pb_value_override_val[6] = timer1_compare_out_b_i;
    pb_value_override_en[5] = timer1_compare_en_a_i;
    pb_value_override_val[5] = timer1_compare_out_a_i;
    pb_value_override_en[4] = timer2_compare_en_a_i;
    pb_value_override_val[4] = timer2_compare_out_a_i;
    // Forced inputs keep their pull-up under the port bit; master forces bit 3 in,
    // slave forces bits 2..0 in, so the two modes never fight over one pin
    pb_pullup_override_en[3:0] = {spi_mst, {3{spi_slv}}};
    pb_direction_override_en[3:0] = {spi_mst, {3{spi_slv}}};
    pb_pullup_override_val[3:0] = pb_data_r[3:0] & {4{!global_pullup_disable}};
    // Bit 3: slave output in SPI slave mode, data out while programming
    if (prog_mode_i)
    begin
      pb_direction_override_en[3] = 1'b1;
      pb_direction_override_val[3] = 1'b1;
      pb_value_override_en[3] = 1'b1;
      pb_value_override_val[3] = prog_serial_data_out_i;
    end
    else
    begin
      pb_value_override_en[3] = spi_slv;
      pb_value_override_val[3] = spi_slave_out_i;
    end
    // Bit 2: programming input, or master output
    if (prog_mode_i)
    begin
      pb_direction_override_en[2] = 1'b1;
      pb_direction_override_val[2] = 1'b0;
      pb_pullup_override_en[2] = 1'b0;
    end
    pb_value_override_en[2] = spi_mst && !prog_mode_i;
    pb_value_override_val[2] = spi_master_out_i;
    pb_value_override_en[1] = spi_mst;
    pb_value_override_val[1] = spi_sck_out_i;
  end

  // ---------------- Pad resolution ----------------
  pin_ctl_type [PIN_COUNT-1:0] pa_ctl;
  pin_ctl_type [PIN_COUNT-1:0] pb_ctl;

  genvar gi;
  generate
    for (gi = 0; gi < PIN_COUNT; gi++)
    begin : g_pin
      // Memory enable drives pull-up, direction and value overrides
      assign pa_ctl[gi] = resolve_pin(pa_dir_r[gi], pa_data_r[gi], global_pullup_disable,
        ext_mem_enable_i,
        !addr_or_wr && pa_data_r[gi] && !global_pullup_disable,
        ext_mem_enable_i, addr_or_wr,
        ext_mem_enable_i, pa_value_override_val[gi],
        1'b0, 1'b0, sleep_i);
      assign pb_ctl[gi] = resolve_pin(pb_dir_r[gi], pb_data_r[gi], global_pullup_disable,
        pb_pullup_override_en[gi], pb_pullup_override_val[gi], pb_direction_override_en[gi], pb_direction_override_val[gi],
        pb_value_override_en[gi], pb_value_override_val[gi], pb_input_enable_override_en[gi], 1'b1, sleep_i);
    end
  endgenerate

  // Pad controls and digital inputs leave from flops; one cycle for controls, three from pad to digital input
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      pa_pad_o    <= '0;
      pa_pad_oe_o <= '0;
      pa_pullup_o <= '0;
      pb_pad_o    <= '0;
      pb_pad_oe_o <= '0;
      pb_pullup_o <= '0;
    end
    else
    begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        pa_pad_o[i]    <= pa_ctl[i].out;
        pa_pad_oe_o[i] <= pa_ctl[i].oe;
        pa_pullup_o[i] <= pa_ctl[i].pu;
        pb_pad_o[i]    <= pb_ctl[i].out;
        pb_pad_oe_o[i] <= pb_ctl[i].oe;
        pb_pullup_o[i] <= pb_ctl[i].pu;
      end
    end
  end

  // Alternate function inputs, gated by each pin's input enable
  always_ff @(posedge clk_sys_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      mem_rdata_o           <= '0;
      pin_change_src_o      <= '0;
      spi_master_in_o       <= 1'b0;
      spi_slave_in_o        <= 1'b0;
      spi_sck_in_o          <= 1'b0;
      spi_ss_in_o           <= 1'b0;
      prog_serial_data_in_o <= 1'b0;
    end
    else
    begin
      for (int i = 0; i < PIN_COUNT; i++)
      begin
        mem_rdata_o[i]      <= pa_sync_r[i] && pa_ctl[i].ie;
        pin_change_src_o[i] <= pb_sync_r[i] && pb_ctl[i].ie;
      end
      spi_master_in_o       <= pb_sync_r[3] && pb_ctl[3].ie;
      spi_slave_in_o        <= pb_sync_r[2] && pb_ctl[2].ie;
      prog_serial_data_in_o <= pb_sync_r[2] && pb_ctl[2].ie;
      spi_sck_in_o          <= pb_sync_r[1] && pb_ctl[1].ie;
      spi_ss_in_o           <= pb_sync_r[0] && pb_ctl[0].ie;
    end
  end

  // ---------------- Checks ----------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_pud_set;
    mcu_control_r[`BIT_GLOBAL_PULLUP_DISABLE] && !ext_mem_enable_i;
  endsequence
  sequence s_mem_idle;
    ext_mem_enable_i && !mem_wr_strobe_i && !address_phase_active_i;
  endsequence

  AST_PUD_KILLS_PULLUPS: assert property (
    s_pud_set |=> (pa_pullup_o == '0) && (pb_pullup_o == '0))
    else $error("pull-up on while globally disabled");
  AST_CTRL_RESERVED_ZERO: assert property (
    (mcu_control_r & ~`MCU_CONTROL_WR_MASK) == 8'h00)
    else $error("reserved control bits set");
  AST_ADDR_ON_PINS: assert property (
    ext_mem_enable_i && address_phase_active_i && !mem_wr_strobe_i
    |=> pa_pad_o == $past(mem_addr_lo_i))
    else $error("address not on port A");
  AST_MEM_PULLUP: assert property (
    s_mem_idle |=> pa_pullup_o == ($past(pa_data_r) & {PIN_COUNT{!$past(global_pullup_disable)}}))
    else $error("port A pull-up wrong while memory idle");
  AST_MEM_DRIVE: assert property (
    ext_mem_enable_i |=> pa_pad_oe_o == {PIN_COUNT{$past(addr_or_wr)}})
    else $error("port A driver wrong under memory");
  AST_WR_DATA: assert property (
    ext_mem_enable_i && mem_wr_strobe_i && !address_phase_active_i
    |=> pa_pad_o == $past(mem_wdata_i))
    else $error("write data not on port A");
  AST_RDATA_PATH: assert property (
    (arst_n_i && !sleep_i) [*4] |-> mem_rdata_o == $past(pa_pad_i, 3))
    else $error("read data does not follow port A");
  AST_NORMAL_PULLUP: assert property (
    !ext_mem_enable_i |=> pa_pullup_o ==
      (~$past(pa_dir_r) & $past(pa_data_r) & {PIN_COUNT{!$past(global_pullup_disable)}}))
    else $error("plain pull-up equation broken");
  AST_TIMER_B6: assert property (
    timer1_compare_en_b_i && pb_dir_r[6] |=> pb_pad_o[6] == $past(timer1_compare_out_b_i))
    else $error("timer1 output B not on port B bit 6");
  AST_MISO_INPUT: assert property (
    spi_mst && !prog_mode_i |=> !pb_pad_oe_o[3])
    else $error("MISO driven in SPI master mode");

endmodule

// [tb/board_pin_model.sv]
`timescale 1ns/1ps
module board_pin_model
(
  // Clock
  input  wire logic       clk_i,
  // Device pad side
  input  wire logic [7:0] pad_o_i,
  input  wire logic [7:0] oe_i,
  input  wire logic [7:0] pullup_i,
  // Board drivers
  input  wire logic [7:0] ext_en_i,
  input  wire logic [7:0] ext_val_i,
  output logic [7:0]      pad_i_o
);
  logic [7:0] last_r = 8'h00;

  // A floating line toggles so no stale level passes for a real one
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (oe_i[i])
        pad_i_o[i] = pad_o_i[i];
      else if (ext_en_i[i])
        pad_i_o[i] = ext_val_i[i];
      else if (pullup_i[i])
        pad_i_o[i] = 1'b1;
      else
        pad_i_o[i] = ~last_r[i];
    end
  end

  // Last level seen on each line
  always_ff @(posedge clk_i)
    last_r <= pad_i_o;
endmodule

// [tb/test_port_alternate_function_mux.sv]
`timescale 1ns/1ps
module test_port_alternate_function_mux;
  import port_mux_pkg::*;
  logic clk_sys_i, arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, sleep_i, ext_mem_enable_i, mem_wr_strobe_i, address_phase_active_i;
  logic timer0_compare_out_a_i, timer0_compare_en_a_i, timer1_compare_out_a_i;
  logic timer1_compare_en_a_i, timer1_compare_out_b_i, timer1_compare_en_b_i;
  logic timer1_compare_out_c_i, timer1_compare_en_c_i, timer2_compare_out_a_i;
  logic timer2_compare_en_a_i, spi_enable_i, spi_master_i, spi_slave_out_i, spi_master_out_i;
  logic spi_sck_out_i, prog_mode_i, prog_serial_data_out_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, scan_port_disable_o;
  logic vector_table_select_o, vector_change_enable_o, spi_master_in_o, spi_slave_in_o;
  logic spi_sck_in_o, spi_ss_in_o, prog_serial_data_in_o;
  logic [3:0]   s_axi_wstrb_i;
  logic [31:0]  s_axi_wdata_i, s_axi_rdata_o;
  axi_resp_type s_axi_bresp_o, s_axi_rresp_o;
  logic [7:0]   s_axi_awaddr_i, s_axi_araddr_i, mem_addr_lo_i, mem_wdata_i, mem_rdata_o;
  logic [7:0]   pa_pad_i, pb_pad_i, pin_change_src_o, pa_pad_o, pa_pad_oe_o, pa_pullup_o;
  logic [7:0]   pb_pad_o, pb_pad_oe_o, pb_pullup_o, pa_en, pa_val, pb_en, pb_val;
  int           err_count = 0;
  int           n_compared = 0;
  axi_resp_type b_resp;

  port_alternate_function_mux dut_u (.*);
  board_pin_model pa_u (.clk_i(clk_sys_i), .pad_o_i(pa_pad_o), .oe_i(pa_pad_oe_o),
    .pullup_i(pa_pullup_o), .ext_en_i(pa_en), .ext_val_i(pa_val), .pad_i_o(pa_pad_i));
  board_pin_model pb_u (.clk_i(clk_sys_i), .pad_o_i(pb_pad_o), .oe_i(pb_pad_oe_o),
    .pullup_i(pb_pullup_o), .ext_en_i(pb_en), .ext_val_i(pb_val), .pad_i_o(pb_pad_i));

  // Free-running 250 MHz clock
  initial
  begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Wait n edges; flop outputs read here still show the edge before this one
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Bus write; each channel released at the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (n = 0; n < 50 && !s_axi_bvalid_o; n++)
    begin
      @(posedge clk_sys_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
    end
    b_resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
    if (n == 50)
    begin
      err_count++;
      test_done();
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_sys_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (n = 0; n < 50 && !s_axi_rvalid_o; n++)
    begin
      @(posedge clk_sys_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
    end
    d = s_axi_rdata_o;
    r = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
    if (n == 50)
    begin
      err_count++;
      test_done();
    end
  endtask

  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    rd(8'h00, d, r);
    chk(d, 32'h0000_0000);
    wr(8'h00, 32'h0000_00FF);
    chk(b_resp, RESP_OKAY);
    rd(8'h00, d, r);
    chk(d, 32'h0000_0093);
    chk({scan_port_disable_o, vector_table_select_o, vector_change_enable_o}, 3'b111);
    rd(8'h40, d, r);
    chk(r, RESP_SLVERR);
    wr(8'h40, 32'h0000_0001);
    chk(b_resp, RESP_SLVERR);
    wr(8'h00, 32'h0000_0000);
  endtask

  task automatic t_pullup;
    wr(8'h04, 32'h0000_00FF);
    wr(8'h08, 32'h0000_000F);
    wr(8'h10, 32'h0000_00FF);
    step(2);
    chk({pa_pullup_o, pb_pullup_o}, 16'hF0FF);
    wr(8'h00, 32'h0000_0010);
    step(2);
    chk({pa_pullup_o, pb_pullup_o}, 16'h0000);
    wr(8'h00, 32'h0000_0000);
    wr(8'h10, 32'h0000_0000);
  endtask

  task automatic t_extmem;
    ext_mem_enable_i <= 1'b1;
    step(2);
    chk({pa_pad_oe_o, pa_pullup_o}, 16'h00FF);
    address_phase_active_i <= 1'b1;
    mem_addr_lo_i <= 8'hA5;
    step(2);
    chk({pa_pad_oe_o, pa_pad_o, pa_pullup_o}, 24'hFF_A500);
    address_phase_active_i <= 1'b0;
    mem_wr_strobe_i <= 1'b1;
    mem_wdata_i <= 8'h3C;
    step(2);
    chk({pa_pad_oe_o, pa_pad_o, pa_pullup_o}, 24'hFF_3C00);
    mem_wr_strobe_i <= 1'b0;
    pa_en <= 8'hFF;
    pa_val <= 8'h5A;
    step(5);
    chk({pa_pad_oe_o, mem_rdata_o}, 16'h005A);
    sleep_i <= 1'b1;
    step(4);
    chk(mem_rdata_o, 8'h00);
    sleep_i <= 1'b0;
    ext_mem_enable_i <= 1'b0;
    pa_en <= 8'h00;
  endtask

  task automatic t_portb;
    wr(8'h14, 32'h0000_00F8);
    {timer0_compare_en_a_i, timer1_compare_en_b_i, timer1_compare_en_a_i} <= 3'b111;
    {timer2_compare_en_a_i, timer0_compare_out_a_i, timer1_compare_out_b_i} <= 3'b111;
    {timer1_compare_out_a_i, timer2_compare_out_a_i} <= 2'b11;
    step(2);
    chk({pb_pad_oe_o[7:4], pb_pad_o[7:4]}, 8'hFF);
    wr(8'h20, 32'h0000_0002);
    timer1_compare_en_c_i <= 1'b1;
    timer1_compare_out_c_i <= 1'b1;
    timer0_compare_out_a_i <= 1'b0;
    step(2);
    chk(pb_pad_o[7], 1'b1);
    spi_enable_i <= 1'b1;
    spi_master_i <= 1'b1;
    step(2);
    chk(pb_pad_oe_o[3], 1'b0);
    spi_master_i <= 1'b0;
    pb_en <= 8'h01;
    step(4);
    chk({pb_pad_oe_o[3], pb_pad_oe_o[0], spi_ss_in_o}, 3'b100);
    // Sleep keeps only the masked pin alive, for its pin-change and SS inputs alike
    wr(8'h1C, 32'h0000_0001);
    wr(8'h20, 32'h0000_0003);
    pb_val <= 8'h07;
    pb_en <= 8'h07;
    sleep_i <= 1'b1;
    step(5);
    chk({pin_change_src_o[2:0], spi_ss_in_o, spi_slave_in_o}, 5'b00110);
    sleep_i <= 1'b0;
    step(4);
    chk({spi_master_in_o, spi_slave_in_o, prog_serial_data_in_o, spi_sck_in_o}, 4'b0111);
    prog_mode_i <= 1'b1;
    prog_serial_data_out_i <= 1'b1;
    step(2);
    chk({pb_pad_oe_o[3:2], pb_pad_o[3]}, 3'b101);
  endtask

  // Main sequence
  initial
  begin
    {arst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
    {s_axi_rready_i, sleep_i, ext_mem_enable_i, mem_wr_strobe_i, address_phase_active_i} = '0;
    {timer0_compare_out_a_i, timer0_compare_en_a_i, timer1_compare_out_a_i} = '0;
    {timer1_compare_en_a_i, timer1_compare_out_b_i, timer1_compare_en_b_i} = '0;
    {timer1_compare_out_c_i, timer1_compare_en_c_i, timer2_compare_out_a_i} = '0;
    {timer2_compare_en_a_i, spi_enable_i, spi_master_i, spi_slave_out_i} = '0;
    {spi_master_out_i, spi_sck_out_i, prog_mode_i, prog_serial_data_out_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, mem_addr_lo_i, mem_wdata_i, s_axi_wdata_i} = '0;
    {pa_en, pa_val, pb_en, pb_val} = '0;
    s_axi_wstrb_i = 4'hF;
    repeat (20) @(posedge clk_sys_i);
    arst_n_i <= 1'b1;
    t_regs();
    t_pullup();
    t_extmem();
    t_portb();
    test_done();
  end
endmodule
